//--- rtl/pll_serial_config_registers.sv
// Serial-loaded eight-word configuration register bank with calibration start
`timescale 1ns/100ps
`include "pll_cfg_map.svh"
module pll_serial_config_registers (
	input wire logic ref_clk_in, // Core clock, 25 MHz
	input wire logic rst_n_in, // Synchronous reset, active low
	input wire logic serial_clk_in, // Link clock from host
	input wire logic serial_data_in, // Serial data, MSB first
	input wire logic load_strobe_in, // Load strobe, commit on rise
	output logic [23:0] integer_word_out, // Register 0 contents
	output logic [10:0] modulus_out, // Modulus field
	output logic [10:0] fraction_out, // Fraction field
	output logic [23:0] dither_word_out, // Register 3 contents
	output logic [23:0] charge_pump_word_out, // Register 4 contents
	output logic [23:0] lo_path_word_out, // Register 5 contents
	output logic [23:0] vco_word_out, // Register 6 contents
	output logic [23:0] mixer_word_out, // Register 7 contents
	output logic cal_start_out, // One-cycle calibration start
	output logic [7:0] written_out // Sticky per-register written flags
);
	pll_cfg_pkg::link_state_t link_r; // Link-domain state
	pll_cfg_pkg::link_state_t link_nxt; // Its next value
	pll_cfg_pkg::core_state_t core_r; // Core-domain state
	pll_cfg_pkg::core_state_t core_nxt; // Its next value
	logic link_rst_n_r; // Reset carried into link domain, stage one
	logic link_rst_n_s; // Reset carried into link domain, stage two
	logic strobe_rise; // Load strobe edge in link domain
	pll_cfg_pkg::cfg_sel_t sel; // Select code of held word
	logic [23:0] rst_vals [8]; // Power-up values per register

	// Power-up value table
	always_comb begin
		rst_vals[0] = `CFG_RST_INTEGER;
		rst_vals[1] = `CFG_RST_MODULUS;
		rst_vals[2] = `CFG_RST_FRACTION;
		rst_vals[3] = `CFG_RST_DITHER;
		rst_vals[4] = `CFG_RST_CHARGE_PUMP;
		rst_vals[5] = `CFG_RST_LO_PATH;
		rst_vals[6] = `CFG_RST_VCO;
		rst_vals[7] = `CFG_RST_MIXER;
	end

	// Reset synchroniser into link domain
	always_ff @(posedge serial_clk_in) begin
		link_rst_n_r <= rst_n_in;
		link_rst_n_s <= link_rst_n_r;
	end

	// Load strobe edge, sampled on the link clock
	always_comb begin
		strobe_rise = link_r.strobe_sync[1] & ~link_r.strobe_sync[2];
	end

	// Link-side next state
	always_comb begin
		link_nxt = link_r;
		// Shift in MSB first; the clock keeps running while the strobe syncs
		link_nxt.shift = {link_r.shift[24:0], serial_data_in};
		link_nxt.strobe_sync = {link_r.strobe_sync[1:0], load_strobe_in};
		// Capture word and flag commit
		if (strobe_rise) begin
			// Two link edges pass before the edge is seen: skip their bits
			// Limitation: strobe must rise between link clock edges, not on one
			link_nxt.load_word = link_r.shift[25:2];
			link_nxt.load_tgl = ~link_r.load_tgl;
		end
	end

	// Link-side registers
	always_ff @(posedge serial_clk_in) begin
		if (!link_rst_n_s) begin
			link_r <= '0;
		end else begin
			link_r <= link_nxt;
		end
	end

	// Select code of the word being handed over
	always_comb begin
		sel = link_r.load_word[`CFG_SEL_LSB +: `CFG_SEL_W];
	end

	// Core next state: toggle crossing, word held stable by the toggle
	always_comb begin
		core_nxt = core_r;
		core_nxt.tgl_sync = {core_r.tgl_sync[1:0], link_r.load_tgl};
		core_nxt.cal_start = 1'b0;
		// New word arrived in core domain
		if (core_r.tgl_sync[2] != core_r.tgl_sync[1]) begin
			core_nxt.regs[sel] = link_r.load_word;
			core_nxt.written[sel] = 1'b1;
			// Calibrate on integer, modulus or fraction writes
			if (sel == `CFG_SEL_INTEGER || sel == `CFG_SEL_MODULUS ||
				sel == `CFG_SEL_FRACTION) begin
				core_nxt.cal_start = 1'b1;
			end
		end
	end

	// Core registers
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < 8; i++) begin
				core_r.regs[i] <= rst_vals[i];
			end
			core_r.tgl_sync <= 3'h0;
			core_r.cal_start <= 1'b0;
			core_r.written <= 8'h00;
		end else begin
			core_r <= core_nxt;
		end
	end

	// Outputs straight from flip-flops
	always_comb begin
		integer_word_out = core_r.regs[0];
		modulus_out = core_r.regs[1][`CFG_FIELD_MSB:`CFG_FIELD_LSB];
		fraction_out = core_r.regs[2][`CFG_FIELD_MSB:`CFG_FIELD_LSB];
		dither_word_out = core_r.regs[3];
		charge_pump_word_out = core_r.regs[4];
		lo_path_word_out = core_r.regs[5];
		vco_word_out = core_r.regs[6];
		mixer_word_out = core_r.regs[7];
		cal_start_out = core_r.cal_start;
		written_out = core_r.written;
	end
endmodule // pll_serial_config_registers

//--- rtl/pll_cfg_map.svh
// Register map constants for the serial configuration register bank
`ifndef PLL_CFG_MAP_SVH
`define PLL_CFG_MAP_SVH
`define CFG_WORD_W 24
`define CFG_SEL_W 3
`define CFG_SEL_LSB 0
`define CFG_SEL_INTEGER 3'h0
`define CFG_SEL_MODULUS 3'h1
`define CFG_SEL_FRACTION 3'h2
`define CFG_FIELD_LSB 3
`define CFG_FIELD_MSB 13
`define CFG_RST_INTEGER 24'h0001C0
`define CFG_RST_MODULUS 24'h003001
`define CFG_RST_FRACTION 24'h001802
`define CFG_RST_DITHER 24'h10000B
`define CFG_RST_CHARGE_PUMP 24'h0AA7E4
`define CFG_RST_LO_PATH 24'h0000E5
`define CFG_RST_VCO 24'h1E2106
`define CFG_RST_MIXER 24'h000007
`endif

//--- rtl/pll_cfg_pkg.sv
// Types shared by the serial configuration register bank
package pll_cfg_pkg;
	typedef logic [23:0] cfg_word_t;
	typedef logic [2:0] cfg_sel_t;
	// Link-domain state
	typedef struct packed {
		logic [25:0] shift; // 24-bit word plus two bits shifted while the strobe syncs
		logic [2:0] strobe_sync; // Load strobe synchroniser and edge history
		logic load_tgl;
		cfg_word_t load_word;
	} link_state_t;
	// Core-domain state
	typedef struct packed {
		cfg_word_t [7:0] regs;
		logic [2:0] tgl_sync;
		logic cal_start;
		logic [7:0] written;
	} core_state_t;
endpackage

//--- sim/pll_cfg_props.sv
// Assertions on the configuration bank outputs
`timescale 1ns/100ps
module pll_cfg_props (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic cal_start_out,
	input wire logic [10:0] modulus_out,
	input wire logic [10:0] fraction_out,
	input wire logic [7:0] written_out,
	input wire logic [23:0] integer_word_out,
	input wire logic [23:0] dither_word_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_cal_single: assert property (cal_start_out |=> !cal_start_out) else $error("cal long");
	a_mod_holds: assert property ($changed(modulus_out) |-> cal_start_out) else $error("mod");
	a_frac_holds: assert property ($changed(fraction_out) |-> cal_start_out) else $error("frac");
	a_int_holds: assert property ($changed(integer_word_out) |-> cal_start_out) else $error("int");
	a_dither_quiet: assert property ($changed(dither_word_out) |-> !cal_start_out) else $error("dith");
	a_written_sticky: assert property ((written_out & $past(written_out)) == $past(written_out))
		else $error("written flag cleared");
	a_reset_values: assert property (disable iff (1'b0) !rst_n_in |=> modulus_out == 11'h600
		&& fraction_out == 11'h300 && written_out == 8'h00) else $error("reset value");
	c_cal: cover property (cal_start_out);
	c_mod_max: cover property (modulus_out == 11'h7FF);
	c_frac_zero: cover property (fraction_out == 11'h000);
endmodule // pll_cfg_props

//--- sim/host_serial.sv
// Host model of the three-wire serial port
`timescale 1ns/100ps
module host_serial (
	output logic sclk_out = 1'b0, // Link clock, idle low
	output logic sdata_out = 1'b0, // Serial data
	output logic strobe_out = 1'b0 // Load strobe
);
	// Free clock cycles
	task tick(input int n);
		repeat (n) begin
			#15 sclk_out = 1'b1;
			#15 sclk_out = 1'b0;
		end
	endtask
	// Word MSB first, strobe held over six clocks
	task send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			sdata_out = w[i];
			tick(1);
		end
		sdata_out = ~w[0];
		strobe_out = 1'b1;
		tick(6);
		strobe_out = 1'b0;
		tick(3);
	endtask
endmodule // host_serial

//--- sim/tb_top.sv
// Bench for the serial configuration bank
`timescale 1ns/100ps
module tb_top;
	logic ref_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic sc, sd, ls, cal;
	logic [7:0] ew = 8'h00;
	logic [10:0] mo, fo;
	logic [7:0] wr;
	wire [23:0] o [8];
	logic [23:0] e [8] = '{24'h0001C0, 24'h003001, 24'h001802, 24'h10000B, 24'h0AA7E4,
		24'h0000E5, 24'h1E2106, 24'h000007};
	logic [23:0] w [9] = '{24'hABCDE7, 24'h5A5A5E, 24'h123454, 24'hF0F0F3, 24'h0FF0F5,
		24'h000A38, 24'h003FF9, 24'h000002, 24'h003FF2};
	int err_total = 0;
	int samples_checked = 0;
	int nc = 0;
	assign o[1] = {10'h0, mo, 3'h1};
	assign o[2] = {10'h0, fo, 3'h2};
	initial forever #20 ref_clk_in = ~ref_clk_in;
	// Count calibration pulses
	always @(posedge ref_clk_in) nc += (cal === 1'b1);
	host_serial u_host_serial (.sclk_out(sc), .sdata_out(sd), .strobe_out(ls));
	pll_serial_config_registers u_pll_serial_config_registers (.ref_clk_in, .rst_n_in,
		.serial_clk_in(sc), .serial_data_in(sd), .load_strobe_in(ls), .integer_word_out(o[0]),
		.modulus_out(mo), .fraction_out(fo), .dither_word_out(o[3]), .charge_pump_word_out(o[4]),
		.lo_path_word_out(o[5]), .vco_word_out(o[6]), .mixer_word_out(o[7]),
		.cal_start_out(cal), .written_out(wr));
	task chk(input logic [23:0] g, x);
		samples_checked++;
		if (g !== x) begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, g, x);
		end
	endtask
	task results;
		$display("compared %0d bad %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Reset, defaults, then each word in host order
	initial begin
		fork
			u_host_serial.tick(5);
			repeat (5) @(negedge ref_clk_in);
		join
		rst_n_in = 1'b1;
		u_host_serial.tick(4);
		for (int i = 0; i < 8; i++) chk(o[i], e[i]);
		chk(24'(wr), 24'(ew));
		$display("defaults done");
		foreach (w[k]) begin
			@(negedge ref_clk_in) nc = 0;
			u_host_serial.send(w[k]);
			repeat (8) @(negedge ref_clk_in);
			e[w[k][2:0]] = w[k];
			ew[w[k][2:0]] = 1'b1;
			chk(24'(wr), 24'(ew));
			for (int i = 0; i < 8; i++) chk(o[i], e[i]);
			chk(24'(nc), 24'(w[k][2:0] < 3));
			$display("word %h done", w[k]);
		end
		results;
	end
	// Watchdog
	initial begin
		#60000 err_total++;
		results;
	end
endmodule // tb_top
bind pll_serial_config_registers pll_cfg_props u_pll_cfg_props (.ref_clk_in, .rst_n_in,
	.cal_start_out, .modulus_out, .fraction_out, .written_out, .integer_word_out,
	.dither_word_out);
